// ==== hw/pdc_divider_c.sv ====
// Purpose: post-divider C of synthesizer 0, divided clock or frame pulse
// Assumes: clk is the synthesizer clock; sibling divider outputs are
//          flops on clk, so they are read without a synchroniser
// Notes: one configuration register, byte access through page select
`timescale 1ns/1ns
`default_nettype none
module pdc_divider_c
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic page_sel,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic rel_clk_a,
    input wire logic rel_clk_b,
    input wire logic rel_clk_d,
    output logic clk_out,
    output logic frame_mode
);
    // ---------------------------------------------------------------
    // host register access
    // ---------------------------------------------------------------
    logic [23:0] cfg_q;
    logic [23:0] cfg_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    wire [7:0] full_addr = {page_sel, reg_addr};
    wire hit_hi = full_addr == pdc_pkg::ADDR_CFG_HI;
    wire hit_mid = full_addr == pdc_pkg::ADDR_CFG_MID;
    wire hit_lo = full_addr == pdc_pkg::ADDR_CFG_LO;
    wire cfg_wr = reg_wr && (hit_hi || hit_mid || hit_lo);

    // byte lane write merge
    always_comb
    begin
        cfg_d = cfg_q;
        if (reg_wr && hit_hi)
        begin
            cfg_d[23:16] = reg_wdata;
        end
        if (reg_wr && hit_mid)
        begin
            cfg_d[15:8] = reg_wdata;
        end
        if (reg_wr && hit_lo)
        begin
            cfg_d[7:0] = reg_wdata;
        end
    end

    // read mux, unmapped addresses read zero
    assign rdata_d = hit_hi ? cfg_q[23:16] :
                     hit_mid ? cfg_q[15:8] :
                     hit_lo ? cfg_q[7:0] : pdc_pkg::RDATA_NONE;

    // configuration and read data registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg_q <= pdc_pkg::CFG_RST;
            rdata_q <= pdc_pkg::RDATA_NONE;
        end
        else
        begin
            cfg_q <= cfg_d;
            if (reg_rd)
            begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------
    wire fm = cfg_q[pdc_pkg::MODE_HI:pdc_pkg::MODE_LO] == pdc_pkg::MODE_FRAME;
    wire fp_type = cfg_q[pdc_pkg::TYPE_BIT];
    wire fp_pol = cfg_q[pdc_pkg::POL_BIT];
    wire [1:0] fp_sel = cfg_q[pdc_pkg::SEL_HI:pdc_pkg::SEL_LO];
    wire [15:0] fp_per = cfg_q[pdc_pkg::PER_HI:pdc_pkg::PER_LO];
    // ratios below two cannot be made from clk, they run as two
    wire [23:0] ratio = (cfg_q < pdc_pkg::RATIO_MIN) ? pdc_pkg::RATIO_MIN : cfg_q;
    wire [23:0] ratio_last = ratio - 24'h000001;
    // high phase is ceil(ratio/2): exact half for even ratios
    wire [23:0] high_len = 24'((25'(ratio) + 25'h0000001) >> 1);
    assign frame_mode = fm;

    // ---------------------------------------------------------------
    // divided clock
    // ---------------------------------------------------------------
    logic [23:0] div_cnt_q;
    logic div_out_q;
    wire [23:0] div_cnt_d = (cfg_wr || div_cnt_q >= ratio_last) ? 24'h000000
                                                                 : div_cnt_q + 24'h000001;

    // ratio counter restarts on every configuration write
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_cnt_q <= 24'h000000;
            div_out_q <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            div_out_q <= div_cnt_d < high_len;
        end
    end

    // ---------------------------------------------------------------
    // related clock selection and edges
    // ---------------------------------------------------------------
    logic rel_q;
    wire sel_ok = fp_sel != pdc_pkg::SEL_RSVD;
    wire rel_now = (fp_sel == pdc_pkg::SEL_A) ? rel_clk_a :
                   (fp_sel == pdc_pkg::SEL_B) ? rel_clk_b :
                   (fp_sel == pdc_pkg::SEL_D) ? rel_clk_d : 1'b0;
    wire rel_rise = rel_now && !rel_q;
    wire rel_fall = !rel_now && rel_q;

    // previous level of the chosen related clock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rel_q <= 1'b0;
        end
        else
        begin
            rel_q <= rel_now;
        end
    end

    // ---------------------------------------------------------------
    // frame pulse
    // ---------------------------------------------------------------
    logic [15:0] per_cnt_q;
    logic fp_q;
    // a period of zero or one pulses on every related period
    wire [15:0] per_last = (fp_per == 16'h0000) ? 16'h0000 : fp_per - 16'h0001;
    wire per_wrap = per_cnt_q >= per_last;
    wire [15:0] per_cnt_d = per_wrap ? 16'h0000 : per_cnt_q + 16'h0001;
    // boundary is the related rising edge that brings the count to zero
    wire boundary = rel_rise && per_wrap;
    // straddling pulse: rises on the falling edge before the boundary
    wire st_set = rel_fall && per_wrap;
    wire fp_d = !sel_ok ? 1'b0 :
                fp_type ? (rel_rise ? boundary : fp_q) :
                (rel_fall ? st_set : fp_q);

    // period counter and pulse level
    always_ff @(posedge clk)
    begin
        if (sys_rst || cfg_wr || !fm)
        begin
            per_cnt_q <= 16'h0000;
            fp_q <= 1'b0;
        end
        else
        begin
            if (rel_rise)
            begin
                per_cnt_q <= per_cnt_d;
            end
            fp_q <= fp_d;
        end
    end

    // ---------------------------------------------------------------
    // output selection
    // ---------------------------------------------------------------
    logic out_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_q <= 1'b0;
        end
        else
        begin
            out_q <= fm ? (fp_q ^ fp_pol) : div_out_q;
        end
    end
    assign clk_out = out_q;

    // ---------------------------------------------------------------
    // duty helper: length of the running high phase in divided mode
    // ---------------------------------------------------------------
    logic cfg_wr_q;
    logic cfg_wr_qq;
    logic [23:0] hi_run_q;
    // output trails the counter by one flop; a write clears the run for three cycles
    wire run_clr = fm || cfg_wr || cfg_wr_q || cfg_wr_qq || !clk_out;
    wire [23:0] hi_run_d = run_clr ? 24'h000000 : hi_run_q + 24'h000001;

    // write history and high phase length
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg_wr_q <= 1'b0;
            cfg_wr_qq <= 1'b0;
            hi_run_q <= 24'h000000;
        end
        else
        begin
            cfg_wr_q <= cfg_wr;
            cfg_wr_qq <= cfg_wr_q;
            hi_run_q <= hi_run_d;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // register access
    chk_reset_value: assert property (@(posedge clk)
        sys_rst |=> cfg_q == pdc_pkg::CFG_RST)
        else $error("config not at reset value");
    chk_page0_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && !page_sel) |=> $stable(cfg_q))
        else $error("page zero write changed the config");
    chk_unmapped_rd: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && !hit_hi && !hit_mid && !hit_lo) |=> reg_rdata == pdc_pkg::RDATA_NONE)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_hi_write: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && hit_hi) |=> cfg_q[pdc_pkg::MODE_HI:pdc_pkg::SEL_LO] == $past(reg_wdata))
        else $error("upper config byte not written");

    // divided clock
    chk_mode_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_d[pdc_pkg::MODE_HI:pdc_pkg::MODE_LO] == pdc_pkg::MODE_FRAME) |=> frame_mode)
        else $error("frame mode flag wrong");
    chk_div_rise: assert property (@(posedge clk) disable iff (sys_rst)
        (!fm && !cfg_wr && div_cnt_q == ratio_last) ##1 !cfg_wr |=> clk_out)
        else $error("divided clock did not rise at wrap");
    chk_even_fall: assert property (@(posedge clk) disable iff (sys_rst)
        (!fm && !ratio[0] && !cfg_wr && div_cnt_q == high_len - 24'h000001) ##1 !cfg_wr |=> !clk_out)
        else $error("even ratio high phase not half");
    chk_high_bound: assert property (@(posedge clk) disable iff (sys_rst)
        !fm |-> hi_run_q <= high_len)
        else $error("divided clock high phase too long");
    chk_div_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !fm |=> clk_out == $past(div_out_q))
        else $error("divided mode output not the divided clock");
    chk_div_idle_fp: assert property (@(posedge clk) disable iff (sys_rst)
        !fm |-> fp_q == 1'b0)
        else $error("frame pulse active in divided mode");

    // frame pulse
    chk_gci_start: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && fp_type && sel_ok && boundary && !cfg_wr) |=> fp_q)
        else $error("gci pulse did not start at boundary");
    chk_gci_end: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && fp_type && fp_q && rel_rise && !boundary && !cfg_wr) |=> !fp_q)
        else $error("gci pulse longer than one period");
    chk_gci_only_bnd: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && fp_type && !fp_q && !cfg_wr) ##1 fp_q |-> $past(boundary))
        else $error("gci pulse started away from the boundary");
    chk_st_straddle: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && !fp_type && sel_ok && st_set && !cfg_wr) |=> fp_q)
        else $error("straddling pulse not raised before boundary");
    chk_st_end: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && !fp_type && fp_q && rel_fall && !st_set && !cfg_wr) |=> !fp_q)
        else $error("straddling pulse longer than one period");
    chk_st_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && !fp_type && sel_ok && !rel_fall && !cfg_wr) |=> fp_q == $past(fp_q))
        else $error("straddling pulse moved off a falling edge");
    chk_per_step: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && rel_rise && !per_wrap && !cfg_wr) |=> per_cnt_q == $past(per_cnt_q) + 16'h0001)
        else $error("period counter missed a related edge");
    chk_per_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && rel_rise && per_wrap && !cfg_wr) |=> per_cnt_q == 16'h0000)
        else $error("period counter did not wrap");
    chk_rsvd_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (fm && !sel_ok) |=> !fp_q)
        else $error("reserved select produced a pulse");
    chk_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        fm |=> clk_out == ($past(fp_q) ^ $past(fp_pol)))
        else $error("frame pulse polarity wrong");
endmodule // pdc_divider_c
`default_nettype wire

// ==== hw/pdc_pkg.sv ====
// Purpose: shared constants for the divider C / frame pulse block
// Assumes: byte wide host access through the page select scheme
// Notes: one 24-bit configuration word over three byte addresses
package pdc_pkg;
    // ---------------------------------------------------------------
    // register map (8-bit device addresses, page 1)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG_HI = 8'h86; // bits 23:16
    localparam logic [7:0] ADDR_CFG_MID = 8'h87; // bits 15:8
    localparam logic [7:0] ADDR_CFG_LO = 8'h88; // bits 7:0
    localparam int CFG_W = 24;
    localparam logic [23:0] CFG_RST = 24'h000040;
    localparam logic [7:0] RDATA_NONE = 8'h00;
    // ---------------------------------------------------------------
    // field layout
    // ---------------------------------------------------------------
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 20;
    localparam logic [3:0] MODE_FRAME = 4'hf;
    localparam int TYPE_BIT = 19;
    localparam int POL_BIT = 18;
    localparam int SEL_HI = 17;
    localparam int SEL_LO = 16;
    localparam int PER_HI = 15;
    localparam int PER_LO = 0;
    localparam int PER_W = 16;
    localparam logic [23:0] RATIO_MIN = 24'h000002;
    localparam logic [23:0] RATIO_MAX = 24'hefffff;
    // related clock select codes
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_RSVD = 2'h2;
    localparam logic [1:0] SEL_D = 2'h3;
endpackage

// ==== tb/pdc_rel_model.sv ====
// Purpose: sibling divider clocks A, B and D seen by divider C
// Assumes: siblings are flops on clk with ratios 4, 8 and 16
// Notes: divider C itself is never offered as a related clock
`timescale 1ns/1ns
`default_nettype none
module pdc_rel_model
(
    input wire logic clk,
    input wire logic sys_rst,
    output logic rel_clk_a,
    output logic rel_clk_b,
    output logic rel_clk_d
);
    // ---------------------------------------------------------------
    // free running count, one bit per sibling
    // ---------------------------------------------------------------
    logic [3:0] cnt_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_q + 4'h1;
    end
    // only A, B and D exist here, so C never feeds itself
    assign rel_clk_a = cnt_q[1];
    assign rel_clk_b = cnt_q[2];
    assign rel_clk_d = cnt_q[3];
endmodule // pdc_rel_model
`default_nettype wire

// ==== tb/postdivider_c_frame_pulse_tb.sv ====
// Purpose: self-checking bench for divider C
// Assumes: byte access with page select high
// Notes: outputs sampled at falling edges
`timescale 1ns/1ns
`default_nettype none
module postdivider_c_frame_pulse_tb;
    logic clk, sys_rst, page_sel, reg_wr, reg_rd, clk_out, frame_mode;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic rel_clk_a, rel_clk_b, rel_clk_d;
    logic [1:0] rsel;
    logic [2:0] hist;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    // ---------------------------------------------------------------
    // design and sibling clocks
    // ---------------------------------------------------------------
    pdc_divider_c pdc_divider_c_inst (.clk(clk), .sys_rst(sys_rst), .page_sel(page_sel),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rel_clk_a(rel_clk_a), .rel_clk_b(rel_clk_b),
        .rel_clk_d(rel_clk_d), .clk_out(clk_out), .frame_mode(frame_mode));
    pdc_rel_model pdc_rel_model_inst (.clk(clk), .sys_rst(sys_rst),
        .rel_clk_a(rel_clk_a), .rel_clk_b(rel_clk_b), .rel_clk_d(rel_clk_d));
    // clock, related clock history and hang guard
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk)
        hist <= {hist[1:0], rsel == 2'h0 ? rel_clk_a : rsel == 2'h1 ? rel_clk_b : rel_clk_d};
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic pg, input logic [6:0] a, input logic wr,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        page_sel <= pg;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= ~wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask
    task automatic wcfg(input logic [23:0] v);
        logic [7:0] q;
        acc(1'b1, pdc_pkg::ADDR_CFG_HI[6:0], 1'b1, v[23:16], q);
        acc(1'b1, pdc_pkg::ADDR_CFG_MID[6:0], 1'b1, v[15:8], q);
        acc(1'b1, pdc_pkg::ADDR_CFG_LO[6:0], 1'b1, v[7:0], q);
    endtask
    task automatic rcfg(output logic [23:0] v);
        acc(1'b1, pdc_pkg::ADDR_CFG_HI[6:0], 1'b0, 8'h00, v[23:16]);
        acc(1'b1, pdc_pkg::ADDR_CFG_MID[6:0], 1'b0, 8'h00, v[15:8]);
        acc(1'b1, pdc_pkg::ADDR_CFG_LO[6:0], 1'b0, 8'h00, v[7:0]);
    endtask
    // counts falling edges until the output shows level v
    task automatic wl(input logic v, output int n);
        n = 0;
        while (clk_out !== v && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic meas(input logic [23:0] r);
        int n, hi, lo;
        chk("frame_mode", 32'h0, frame_mode);
        wl(1'b0, n);
        wl(1'b1, n);
        wl(1'b0, hi);
        wl(1'b1, lo);
        chk("high phase", (r + 24'h1) / 24'h2, hi);
        chk("period", r, hi + lo);
        $display("done: divided ratio %0d", r);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        logic [23:0] v;
        logic [7:0] q;
        rcfg(v);
        chk("cfg reset", pdc_pkg::CFG_RST, v);
        meas(24'h000040);
        wcfg(24'h123456);
        chk("frame_mode", 32'h0, frame_mode);
        acc(1'b0, 7'h06, 1'b1, 8'hff, q);
        acc(1'b0, 7'h06, 1'b0, 8'h00, q);
        chk("page0 read", 32'h0, q);
        acc(1'b1, 7'h09, 1'b0, 8'h00, q);
        chk("unmapped read", 32'h0, q);
        rcfg(v);
        chk("cfg readback", 24'h123456, v);
        $display("done: registers");
    endtask
    task automatic frm(input logic [1:0] s, input logic [15:0] per, input logic ty,
                       input logic pol);
        int n, w, g, rp;
        rsel = s;
        rp = (s == 2'h0) ? 4 : (s == 2'h1) ? 8 : 16;
        wcfg({4'hf, ty, pol, s, per});
        chk("frame_mode", 32'h1, frame_mode);
        wl(pol, n);
        wl(~pol, n);
        wl(pol, n);
        wl(~pol, n);
        chk("pulse start", ty ? 32'h2 : 32'h1, {hist[1], hist[2]});
        wl(pol, w);
        wl(~pol, g);
        chk("pulse width", rp, w);
        chk("pulse spacing", per * rp, w + g);
        $display("done: frame select %0d", s);
    endtask
    task automatic t_rsvd;
        int n;
        wcfg(24'hf60002);
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            if (clk_out !== 1'b1)
                n++;
        end
        chk("reserved idle", 32'h0, n);
        $display("done: reserved select");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence; ratios stay below the maximum, 7 shows an odd case
    initial
    begin
        sys_rst = 1'b1;
        page_sel = 1'b1;
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        rsel = 2'h0;
        hist = 3'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        wcfg(24'h000002);
        meas(24'h000002);
        wcfg(24'h000007);
        meas(24'h000007);
        wcfg(24'h000029);
        meas(24'h000029);
        frm(2'h0, 16'h0003, 1'b1, 1'b0);
        frm(2'h1, 16'h0003, 1'b0, 1'b1);
        frm(2'h3, 16'h0002, 1'b1, 1'b0);
        frm(2'h0, 16'h0004, 1'b1, 1'b1);
        t_rsvd();
        tally_and_finish();
    end
endmodule // postdivider_c_frame_pulse_tb
`default_nettype wire
